// File: rtl/uft_frame_timer.sv
// Frame interval, frame remaining and frame number counters with command access
// Notes on behaviour
// - Interval field holds frame length, bits 13:0
// - Controller reset returns interval to 11999
// - Budget field loads packet counter each frame
// - Remaining counter decrements once per bit time
// - At zero, remaining reloads interval next bit
// - At zero, interval toggle copies to remaining
// - Entering operation loads remaining from interval
// - Frame number counter, 16 bits, resets zero
// - Interval read 0D, written 8D
// - Remaining read 0E, writes have no effect
// - Reload bumps frame number, flags frame start
// - Frame number read 0F, never written
module uft_frame_timer import uft_pkg::*; #(
    parameter int CLOCK_HZ = UFT_CLOCK_HZ, // System clock rate
    parameter int BIT_HZ = UFT_BIT_RATE_HZ // Full-speed bit rate
) (
    input wire logic i_clock, // System clock, 125 MHz
    input wire logic i_rst, // Synchronous reset, active high
    input wire uft_cmd_s i_cmd, // Command from the microprocessor bus
    input wire logic i_controller_reset_cmd, // Controller reset command pulse
    input wire logic i_operational_state, // High while in operational state
    output uft_rsp_s o_rsp, // Read answer, one cycle after the command
    output logic o_frame_start_flag, // One-cycle pulse at every frame start
    output logic [13:0] o_frame_remaining, // Bit times left in this frame
    output logic [15:0] o_frame_number, // Current frame number
    output logic [14:0] o_largest_packet_budget // Largest packet counter
);
    // Build the interval register image; reserved bits read zero
    function automatic logic [31:0] interval_word(input logic toggle, input logic [14:0] budget,
                                                  input logic [13:0] interval);
        logic [31:0] word;
        word = UFT_WORD_ZERO;
        word[UFT_TOGGLE_BIT] = toggle;
        word[UFT_LPB_LSB +: UFT_LPB_W] = budget;
        word[UFT_FI_LSB +: UFT_FI_W] = interval;
        return word;
    endfunction : interval_word

    // Build the remaining register image; reserved bits read zero
    function automatic logic [31:0] remaining_word(input logic toggle, input logic [13:0] remaining);
        logic [31:0] word;
        word = UFT_WORD_ZERO;
        word[UFT_TOGGLE_BIT] = toggle;
        word[UFT_FR_LSB +: UFT_FI_W] = remaining;
        return word;
    endfunction : remaining_word

    logic bit_tick; // Bit-time enable from the divider
    logic [13:0] frame_interval_reg; // Programmed frame length
    logic [14:0] budget_cfg_reg; // Programmed largest packet budget
    logic interval_toggle_reg; // Toggle written by software
    logic remaining_toggle_reg; // Toggle copied at frame end
    logic oper_prev_reg; // Operational state one cycle ago
    logic soft_reset; // Hardware or controller reset
    logic oper_entry; // Operational state just entered
    logic running; // Counters are live
    logic reload_now; // Remaining is already zero on this bit time, so it reloads
    logic frame_start; // A new frame begins this cycle
    logic write_interval; // Interval write command this cycle

    // Bit-time divider
    uft_bit_tick #(
        .CLOCK_HZ(CLOCK_HZ),
        .BIT_HZ(BIT_HZ)
    ) u_bit_tick (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .o_tick(bit_tick)
    );

    // Event decode; the controller reset command acts like a reset of the counters
    assign soft_reset = i_rst || i_controller_reset_cmd;
    assign oper_entry = i_operational_state && !oper_prev_reg;
    assign running = i_operational_state && oper_prev_reg;
    assign reload_now = running && bit_tick && (o_frame_remaining == '0);
    assign frame_start = oper_entry || reload_now;
    assign write_interval = i_cmd.valid && (i_cmd.code == UFT_CMD_WR_INTERVAL);

    // Operational edge detector; input comes from controller logic on this clock
    always_ff @(posedge i_clock) begin
        if (soft_reset) begin
            oper_prev_reg <= 1'b0;
        end else begin
            oper_prev_reg <= i_operational_state;
        end
    end

    // Interval register: reset to nominal, written only by its write code
    always_ff @(posedge i_clock) begin
        if (soft_reset) begin
            frame_interval_reg <= UFT_FI_NOMINAL;
            budget_cfg_reg <= UFT_LPB_RESET;
            interval_toggle_reg <= 1'b0;
        end else if (write_interval) begin
            // Reserved bits 15:14 are dropped here
            frame_interval_reg <= i_cmd.data[UFT_FI_LSB +: UFT_FI_W];
            budget_cfg_reg <= i_cmd.data[UFT_LPB_LSB +: UFT_LPB_W];
            interval_toggle_reg <= i_cmd.data[UFT_TOGGLE_BIT];
        end
    end

    // Remaining counter: load on entry, reload at zero, else count down per bit time
    always_ff @(posedge i_clock) begin
        if (soft_reset) begin
            o_frame_remaining <= '0;
        end else if (oper_entry) begin
            o_frame_remaining <= frame_interval_reg;
        end else if (reload_now) begin
            // Uses whatever interval stands now, so a trim takes effect next frame
            o_frame_remaining <= frame_interval_reg;
        end else if (running && bit_tick) begin
            o_frame_remaining <= o_frame_remaining - 14'h0001;
        end
    end

    // Remaining toggle follows the interval toggle once per frame
    always_ff @(posedge i_clock) begin
        if (soft_reset) begin
            remaining_toggle_reg <= 1'b0;
        end else if (reload_now) begin
            remaining_toggle_reg <= interval_toggle_reg;
        end
    end

    // Frame number: counts frame starts, wraps naturally past all ones
    always_ff @(posedge i_clock) begin
        if (soft_reset) begin
            o_frame_number <= UFT_FN_RESET;
        end else if (frame_start) begin
            o_frame_number <= o_frame_number + 16'h0001;
        end
    end

    // Frame start pulse feeds the interrupt status logic outside
    always_ff @(posedge i_clock) begin
        if (soft_reset) begin
            o_frame_start_flag <= 1'b0;
        end else begin
            o_frame_start_flag <= frame_start;
        end
    end

    // Largest packet counter: loaded each frame, drains per bit time, stops at zero
    always_ff @(posedge i_clock) begin
        if (soft_reset) begin
            o_largest_packet_budget <= UFT_LPB_RESET;
        end else if (frame_start) begin
            o_largest_packet_budget <= budget_cfg_reg;
        end else if (running && bit_tick && o_largest_packet_budget != '0) begin
            o_largest_packet_budget <= o_largest_packet_budget - 15'h0001;
        end
    end

    // Read answers; write codes and unknown codes never answer, so writes to the
    // read-only registers fall through with no effect
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_rsp <= '0;
        end else begin
            o_rsp.valid <= 1'b0;
            o_rsp.data <= UFT_WORD_ZERO;
            if (i_cmd.valid) begin
                case (i_cmd.code)
                    UFT_CMD_RD_INTERVAL: begin
                        o_rsp.valid <= 1'b1;
                        o_rsp.data <= interval_word(interval_toggle_reg, budget_cfg_reg,
                                                    frame_interval_reg);
                    end
                    UFT_CMD_RD_REMAINING: begin
                        o_rsp.valid <= 1'b1;
                        o_rsp.data <= remaining_word(remaining_toggle_reg, o_frame_remaining);
                    end
                    UFT_CMD_RD_NUMBER: begin
                        o_rsp.valid <= 1'b1;
                        o_rsp.data <= {16'h0000, o_frame_number};
                    end
                    default: begin
                        o_rsp.valid <= 1'b0; // Writes and unmapped codes
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    interval_nominal_a: assert property (i_controller_reset_cmd
        |=> frame_interval_reg == UFT_FI_NOMINAL)
        else $error("interval not nominal after controller reset");
    interval_write_a: assert property (write_interval && !i_controller_reset_cmd
        |=> frame_interval_reg == $past(i_cmd.data[UFT_FI_LSB +: UFT_FI_W])
            && interval_toggle_reg == $past(i_cmd.data[UFT_TOGGLE_BIT]))
        else $error("interval write not stored");
    remaining_decrement_a: assert property (running && bit_tick && !soft_reset
        && o_frame_remaining != 14'h0000 |=> o_frame_remaining == $past(o_frame_remaining) - 14'h0001)
        else $error("remaining did not count down");
    remaining_hold_a: assert property (!bit_tick && !oper_entry && !soft_reset
        |=> $stable(o_frame_remaining))
        else $error("remaining moved without a tick");
    remaining_reload_a: assert property (reload_now && !i_controller_reset_cmd
        |=> o_frame_remaining == $past(frame_interval_reg) && remaining_toggle_reg == $past(interval_toggle_reg))
        else $error("reload or toggle copy missing");
    entry_load_a: assert property (oper_entry && !i_controller_reset_cmd
        |=> o_frame_remaining == $past(frame_interval_reg) ##0 o_frame_start_flag)
        else $error("operational entry did not load");
    number_step_a: assert property (reload_now && !i_controller_reset_cmd
        |=> o_frame_number == $past(o_frame_number) + 16'h0001 ##0 o_frame_start_flag)
        else $error("frame number or start flag wrong");
    budget_load_a: assert property (frame_start && !i_controller_reset_cmd
        |=> o_largest_packet_budget == $past(budget_cfg_reg))
        else $error("budget not loaded at frame start");
    // Between frame starts the budget drains one per bit time and then sticks at zero
    budget_drain_a: assert property (running && bit_tick && !frame_start && !i_controller_reset_cmd
        |=> o_largest_packet_budget == ($past(o_largest_packet_budget) == 15'h0000 ? 15'h0000
            : $past(o_largest_packet_budget) - 15'h0001))
        else $error("budget did not drain or saturate");
    read_remaining_a: assert property (i_cmd.valid && i_cmd.code == UFT_CMD_RD_REMAINING
        |=> o_rsp.valid && o_rsp.data[30:14] == 17'h00000 && o_rsp.data[13:0] == $past(o_frame_remaining))
        else $error("remaining read wrong");
    read_number_a: assert property (i_cmd.valid && i_cmd.code == UFT_CMD_RD_NUMBER
        |=> o_rsp.valid && o_rsp.data == {16'h0000, $past(o_frame_number)})
        else $error("frame number read wrong");
    read_interval_a: assert property (i_cmd.valid && i_cmd.code == UFT_CMD_RD_INTERVAL
        |=> o_rsp.valid && o_rsp.data[15:14] == 2'b00 && o_rsp.data[13:0] == $past(frame_interval_reg))
        else $error("interval read wrong");
endmodule : uft_frame_timer

// File: rtl/uft_pkg.sv
// Shared constants and carrier types for the host frame timing counters
package uft_pkg;
    // Command codes on the microprocessor bus
    localparam logic [7:0] UFT_CMD_RD_INTERVAL = 8'h0d; // Read interval register
    localparam logic [7:0] UFT_CMD_WR_INTERVAL = 8'h8d; // Write interval register
    localparam logic [7:0] UFT_CMD_RD_REMAINING = 8'h0e; // Read remaining register
    localparam logic [7:0] UFT_CMD_RD_NUMBER = 8'h0f; // Read frame number register
    localparam int UFT_CMD_WRITE_BIT = 7; // Set in every write code

    // Field layout of the three frame registers
    localparam int UFT_FI_LSB = 0; // Frame interval low bit
    localparam int UFT_FI_W = 14; // Frame interval width
    localparam int UFT_LPB_LSB = 16; // Largest packet budget low bit
    localparam int UFT_LPB_W = 15; // Largest packet budget width
    localparam int UFT_TOGGLE_BIT = 31; // Interval and remaining toggle position
    localparam int UFT_FR_LSB = 0; // Frame remaining low bit
    localparam int UFT_FN_LSB = 0; // Frame number low bit
    localparam int UFT_FN_W = 16; // Frame number width

    // Reset values
    localparam logic [13:0] UFT_FI_NOMINAL = 14'h2edf; // 11999 bit times
    localparam logic [14:0] UFT_LPB_RESET = 15'h0000; // Budget after reset
    localparam logic [15:0] UFT_FN_RESET = 16'h0000; // Frame number after reset
    localparam logic [31:0] UFT_WORD_ZERO = 32'h0000_0000; // Reserved bits and idle data

    // Timing: system clock and full-speed bit rate
    localparam int UFT_CLOCK_HZ = 125_000_000; // System clock rate
    localparam int UFT_BIT_RATE_HZ = 12_000_000; // Full-speed bit rate
    localparam int UFT_RATE_UNIT_HZ = 1_000_000; // Common divisor for the tick ratio

    // One command from the microprocessor bus
    typedef struct packed {
        logic valid; // Command present this cycle
        logic [7:0] code; // Command code, bit 7 marks a write
        logic [31:0] data; // Write data
    } uft_cmd_s;

    // One read answer back to the microprocessor bus
    typedef struct packed {
        logic valid; // Answer present this cycle
        logic [31:0] data; // Read data
    } uft_rsp_s;
endpackage : uft_pkg

// File: rtl/uft_bit_tick.sv
// Bit-time tick generator: fractional divider from the system clock
module uft_bit_tick import uft_pkg::*; #(
    parameter int CLOCK_HZ = UFT_CLOCK_HZ, // System clock rate
    parameter int BIT_HZ = UFT_BIT_RATE_HZ // Tick rate
) (
    input wire logic i_clock, // System clock
    input wire logic i_rst, // Synchronous reset, active high
    output logic o_tick // One-cycle pulse per bit time
);
    localparam int ACC_W = 16; // Accumulator width
    localparam logic [ACC_W-1:0] STEP = ACC_W'(BIT_HZ / UFT_RATE_UNIT_HZ); // Added each cycle
    localparam logic [ACC_W-1:0] MODULUS = ACC_W'(CLOCK_HZ / UFT_RATE_UNIT_HZ); // Wrap point

    // Ticks must be at most every other cycle, and the ratio must fit the accumulator
    if (2 * BIT_HZ > CLOCK_HZ || CLOCK_HZ / UFT_RATE_UNIT_HZ >= (1 << (ACC_W - 1))) begin : g_bad_rate
        $error("uft_bit_tick: unsupported clock to bit rate ratio");
    end

    logic [ACC_W-1:0] phase_reg; // Fractional phase
    logic [ACC_W-1:0] phase_sum; // Phase plus one step

    assign phase_sum = phase_reg + STEP;

    // Phase accumulator: 12 of every 125 clocks produce a tick, with no long-term drift
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            phase_reg <= '0;
            o_tick <= 1'b0;
        end else if (phase_sum >= MODULUS) begin
            phase_reg <= phase_sum - MODULUS;
            o_tick <= 1'b1;
        end else begin
            phase_reg <= phase_sum;
            o_tick <= 1'b0;
        end
    end

    // Ticks are never adjacent at this ratio
    tick_spacing_a: assert property (@(posedge i_clock) disable iff (i_rst)
        o_tick |=> !o_tick) else $error("bit tick pulses back to back");
endmodule : uft_bit_tick

// File: verification/usb_host_frame_timing_counters_tb_top.sv
// Self-checking testbench for the frame timing counters and their command access
module usb_host_frame_timing_counters_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import uft_pkg::*;
    logic i_clock; // System clock, 8 ns period
    logic i_rst; // Synchronous reset, active high
    uft_cmd_s i_cmd; // Command into the block
    logic i_controller_reset_cmd; // Controller reset pulse
    logic i_operational_state; // Operational level
    uft_rsp_s o_rsp; // Read answer
    logic o_frame_start_flag; // Frame start pulse
    logic [13:0] o_frame_remaining; // Remaining bit times
    logic [15:0] o_frame_number; // Frame number
    logic [14:0] o_largest_packet_budget; // Packet budget counter
    int mismatches = 0; // Failed comparisons
    int check_count = 0; // All comparisons
    logic mon_on = 1'b0; // Frame monitor armed
    logic prev_chg = 1'b0; // Remaining moved in the previous cycle
    logic [13:0] prev_rem = 14'h0; // Remaining seen last cycle
    logic [13:0] last_rl; // Value loaded at the last reload
    logic [13:0] exp_iv; // Interval the next reload must use
    logic [14:0] exp_lpb; // Budget the next reload must load
    logic [15:0] exp_fn; // Frame number the bench expects
    logic [7:0] bad_codes [3] = '{8'h8e, 8'h8f, 8'h10}; // Codes that must never answer
    int ticks = 0; // Bit ticks seen by the monitor
    int ticks_f = 0; // Ticks since the last reload
    int t0; // Tick count at start of the rate window

    uft_frame_timer u_uft_frame_timer (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_cmd(i_cmd),
        .i_controller_reset_cmd(i_controller_reset_cmd),
        .i_operational_state(i_operational_state),
        .o_rsp(o_rsp),
        .o_frame_start_flag(o_frame_start_flag),
        .o_frame_remaining(o_frame_remaining),
        .o_frame_number(o_frame_number),
        .o_largest_packet_budget(o_largest_packet_budget)
    );

    // Free-running clock
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    // Compare and count; case inequality so unknowns never match
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Single place where the run ends
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // One command cycle; the answer, if any, is settled on return
    task automatic send(input logic [7:0] code, input logic [31:0] data);
        @(posedge i_clock);
        #1;
        i_cmd = '{1'b1, code, data};
        @(posedge i_clock);
        #1;
        i_cmd = '{1'b0, 8'h00, 32'h0};
    endtask : send

    // Read with a masked compare of the returned word
    task automatic rd(input string name, input logic [7:0] code, input logic [31:0] exp, input logic [31:0] mask);
        send(code, 32'h0);
        check("rsp_valid", {31'h0, o_rsp.valid}, 32'h1);
        check(name, o_rsp.data & mask, exp);
    endtask : rd

    // Interval write, which never answers
    task automatic wr(input logic [31:0] data);
        send(UFT_CMD_WR_INTERVAL, data);
        check("wr_no_rsp", {31'h0, o_rsp.valid}, 32'h0);
    endtask : wr

    // Bounded wait for a number of frame start pulses
    task automatic wait_flags(input int n);
        int k;
        k = 0;
        for (int c = 0; c < 5000 && k < n; c++) begin
            @(posedge i_clock);
            #1;
            if (o_frame_start_flag === 1'b1) k++;
        end
        check("wait_flags", 32'(k), 32'(n));
        if (k < n) begin
            summarize();
        end
    endtask : wait_flags

    // Frame monitor: every move of remaining is a decrement or a reload
    always @(posedge i_clock) begin
        if (mon_on && o_frame_remaining !== prev_rem) begin
            ticks++;
            ticks_f++;
            check("tick_gap", {31'h0, prev_chg}, 32'h0);
            if (prev_rem == 14'h0) begin
                check("reload", 32'(o_frame_remaining), 32'(exp_iv));
                check("frame_len", 32'(ticks_f), 32'(last_rl) + 32'h1);
                exp_fn = exp_fn + 16'h1;
                check("fn_inc", 32'(o_frame_number), 32'(exp_fn));
                check("flag_set", {31'h0, o_frame_start_flag}, 32'h1);
                check("lpb_load", 32'(o_largest_packet_budget), 32'(exp_lpb));
                last_rl = o_frame_remaining;
                ticks_f = 0;
            end else begin
                check("dec", 32'(o_frame_remaining), 32'(prev_rem) - 32'h1);
                check("flag_idle", {31'h0, o_frame_start_flag}, 32'h0);
            end
        end
        // A design tick on two adjacent clocks would trip tick_gap above
        prev_chg = mon_on && (o_frame_remaining !== prev_rem);
        prev_rem = o_frame_remaining;
    end

    // Hang guard well beyond the planned run
    initial begin
        repeat (100000) @(posedge i_clock);
        check("run_time", 32'h0, 32'h1);
        summarize();
    end

    // Main sequence
    initial begin
        i_rst = 1'b1;
        i_cmd = '{1'b0, 8'h00, 32'h0};
        i_controller_reset_cmd = 1'b0;
        i_operational_state = 1'b0;
        repeat (10) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        rd("iv_rst", UFT_CMD_RD_INTERVAL, 32'h0000_2edf, 32'hffff_ffff);
        rd("rem_rst", UFT_CMD_RD_REMAINING, 32'h0, 32'hffff_ffff);
        rd("fn_rst", UFT_CMD_RD_NUMBER, 32'h0, 32'hffff_ffff);
        // Reserved bits 15:14 must be dropped on write; the toggle takes bit 31 of the written word
        wr(32'hffff_c123);
        rd("iv_wr", UFT_CMD_RD_INTERVAL, 32'hffff_0123, 32'hffff_ffff);
        foreach (bad_codes[i]) begin
            send(bad_codes[i], 32'h1234_5678);
            check("bad_no_rsp", {31'h0, o_rsp.valid}, 32'h0);
        end
        rd("iv_keep", UFT_CMD_RD_INTERVAL, 32'hffff_0123, 32'hffff_ffff);
        rd("rem_keep", UFT_CMD_RD_REMAINING, 32'h0, 32'hffff_ffff);
        rd("fn_keep", UFT_CMD_RD_NUMBER, 32'h0, 32'hffff_ffff);
        // Short frames so many reloads fit in the run; the bench works out the budget
        exp_iv = 14'h5;
        exp_lpb = 15'h3;
        wr(32'h0003_0005);
        i_operational_state = 1'b1;
        wait_flags(1);
        check("entry_rem", 32'(o_frame_remaining), 32'h5);
        check("entry_fn", 32'(o_frame_number), 32'h1);
        check("entry_lpb", 32'(o_largest_packet_budget), 32'h3);
        prev_rem = o_frame_remaining;
        last_rl = 14'h5;
        exp_fn = 16'h1;
        ticks_f = 0;
        mon_on = 1'b1;
        t0 = ticks;
        repeat (1250) @(posedge i_clock);
        #1;
        check("tick_rate", 32'((ticks - t0) >= 119 && (ticks - t0) <= 121), 32'h1);
        rd("rem_tog_clr", UFT_CMD_RD_REMAINING, 32'h0000_0000, 32'hffff_c000);
        // Trim at a frame start; the running frame keeps its old length
        wait_flags(1);
        wr(32'h8002_0007);
        exp_iv = 14'h7;
        exp_lpb = 15'h2;
        wait_flags(3);
        // One more edge so the monitor still sees the last reload
        @(posedge i_clock);
        #1;
        i_operational_state = 1'b0;
        mon_on = 1'b0;
        rd("rem_tog_set", UFT_CMD_RD_REMAINING, 32'h8000_0000, 32'hffff_c000);
        send(8'h8e, 32'hffff_ffff);
        rd("rem_hold", UFT_CMD_RD_REMAINING, 32'(exp_iv), 32'h0000_3fff);
        // A driver would extend this 16-bit count into a wider one in software
        rd("fn_run", UFT_CMD_RD_NUMBER, 32'(exp_fn), 32'hffff_ffff);
        // Driver keeps the interval before a controller reset
        rd("iv_save", UFT_CMD_RD_INTERVAL, 32'h8002_0007, 32'hffff_ffff);
        // Controller reset wins over a write in the same cycle
        @(posedge i_clock);
        #1;
        i_controller_reset_cmd = 1'b1;
        i_cmd = '{1'b1, UFT_CMD_WR_INTERVAL, 32'h0000_0100};
        @(posedge i_clock);
        #1;
        i_controller_reset_cmd = 1'b0;
        i_cmd = '{1'b0, 8'h00, 32'h0};
        rd("iv_crst", UFT_CMD_RD_INTERVAL, 32'h0000_2edf, 32'hffff_ffff);
        rd("fn_crst", UFT_CMD_RD_NUMBER, 32'h0, 32'hffff_ffff);
        rd("rem_crst", UFT_CMD_RD_REMAINING, 32'h0, 32'hffff_ffff);
        // Saved value goes back, toggle flipped against the cleared one
        wr(32'h8002_0007);
        rd("iv_restore", UFT_CMD_RD_INTERVAL, 32'h8002_0007, 32'hffff_ffff);
        summarize();
    end
endmodule : usb_host_frame_timing_counters_tb_top
